// ---- pcs_pkg.sv ----
package pcs_pkg;
    // software-facing register indices of the controller
    localparam logic [3:0] SW_CMD = 4'h0;
    localparam logic [3:0] SW_PERIOD = 4'h1;
    localparam logic [3:0] SW_DUTY_HI = 4'h2;
    localparam logic [3:0] SW_DUTY_LO = 4'h3;
    localparam logic [3:0] SW_PRESCALE = 4'h4;
    localparam logic [3:0] SW_CONFIG = 4'h5;
    localparam logic [3:0] SW_PINMASK = 4'h6;
    localparam logic [3:0] SW_STATUS = 4'h7;
    localparam logic [3:0] SW_INT_STAT = 4'h8;
    localparam logic [3:0] SW_INT_MASK = 4'h9;
    // command register fields
    localparam int CMD_START_BIT = 0;
    localparam int CMD_PARTIAL_BIT = 1;
    localparam int CMD_INTERNAL_BIT = 2;
    // interrupt status fields
    localparam int INT_DONE_BIT = 0;
    localparam int INT_TIMEOUT_BIT = 1;
    // device register addresses, reached over the device access port
    localparam logic [7:0] DEV_PIN_DIRECTION = 8'h00;
    localparam logic [7:0] DEV_PULSE_CHANNEL_CONTROL = 8'h01;
    localparam logic [7:0] DEV_PERIOD_REGISTER = 8'h02;
    localparam logic [7:0] DEV_DUTY_HIGH_REGISTER = 8'h03;
    localparam logic [7:0] DEV_DUTY_LOW_REGISTER = 8'h04;
    localparam logic [7:0] DEV_PERIPHERAL_FLAG_REGISTER_ONE = 8'h05;
    localparam logic [7:0] DEV_PERIOD_TIMER_CONTROL = 8'h06;
    // device field positions
    localparam int TIMER_OVERFLOW_FLAG_BIT = 1;
    localparam int TIMER_ON_BIT = 7;
    localparam int PRESCALE_SELECT_LSB = 4;
    localparam int CHANNEL_ENABLE_BIT = 7;
    localparam int PULSE_OUTPUT_ENABLE_BIT = 6;
    localparam logic [7:0] DUTY_LOW_KEEP_MASK = 8'h3f;
    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_INT = 2'h0;
    // default overflow wait, in polls
    localparam int POLL_LIMIT_DEFAULT = 65536;
    typedef enum {
        PCS_IDLE, PCS_DIR_OFF, PCS_CTRL_CLR, PCS_PERIOD, PCS_DUTY_HI, PCS_DUTY_LO,
        PCS_FLAG_RD, PCS_FLAG_WR, PCS_PRESCALE, PCS_TMR_ON, PCS_OUT_EN,
        PCS_POLL_RD, PCS_POLL_CHK, PCS_DIR_ON, PCS_OE_SET, PCS_FINAL,
        PCS_LOAD_HI, PCS_LOAD_LO
    } pcs_state_t;
endpackage

// ---- pcs_startup_ctrl.sv ----
// How it works
// - first set pin directions to input
// - then write channel control to zero
// - third, load the period register
// - fourth, clear duty high and duty low 7:6
// - clear overflow flag before timer start
// - program prescale select before enabling timer
// - then set the timer on bit
// - enable the channel, wait for overflow flag
// - then drive pins, set output enable
// - then write channel control with configuration, then load duty
// - strict order; partial mode moves final write
// - internal-only use keeps pin outputs disabled
module pcs_startup_ctrl
    import pcs_pkg::*;
#(
    parameter int POLL_LIMIT = POLL_LIMIT_DEFAULT
) (
    input wire logic ref_clk_in, // 25 MHz clock
    input wire logic rst_in, // synchronous reset, active high
    input wire logic [3:0] sw_addr_in, // software register index
    input wire logic [7:0] sw_wdata_in, // software write data
    input wire logic sw_wr_in, // software write strobe
    input wire logic sw_rd_in, // software read strobe
    output logic [7:0] sw_rdata_out, // read data, cycle after strobe
    output logic irq_out, // level interrupt
    output logic [7:0] dev_addr_out, // device register address
    output logic [7:0] dev_wdata_out, // device write data
    output logic dev_wr_out, // device write strobe
    output logic dev_rd_out, // device read strobe
    input wire logic [7:0] dev_rdata_in // device read data, cycle after read
);
    localparam logic [16:0] POLL_MAX = 17'(POLL_LIMIT - 1);

    pcs_state_t state_reg, state_next;
    logic partial_reg, partial_next;
    logic internal_reg, internal_next;
    logic [7:0] period_reg, period_next;
    logic [7:0] duty_hi_reg, duty_hi_next;
    logic [7:0] duty_lo_reg, duty_lo_next;
    logic [2:0] prescale_reg, prescale_next;
    logic [7:0] config_reg, config_next;
    logic [7:0] pinmask_reg, pinmask_next;
    logic [1:0] int_stat_reg, int_stat_next;
    logic [1:0] int_mask_reg, int_mask_next;
    logic [16:0] poll_cnt_reg, poll_cnt_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wr_reg, wr_next;
    logic rd_reg, rd_next;
    logic start_ok, ev_done, ev_timeout;

    function automatic logic sw_hit(input logic [3:0] a, input logic [3:0] idx, input logic strobe);
        return strobe && (a == idx);
    endfunction

    // configuration as finally written; internal use never sets the pin enable
    function automatic logic [7:0] final_cfg(input logic [7:0] cfg, input logic internal);
        logic [7:0] v;
        v = cfg;
        if (internal) begin
            v[PULSE_OUTPUT_ENABLE_BIT] = 1'b0;
        end
        return v;
    endfunction

    assign start_ok = sw_hit(sw_addr_in, SW_CMD, sw_wr_in) && sw_wdata_in[CMD_START_BIT] && (state_reg == PCS_IDLE);

    always_comb begin
        state_next = state_reg;
        partial_next = partial_reg;
        internal_next = internal_reg;
        poll_cnt_next = poll_cnt_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        wr_next = 1'b0;
        rd_next = 1'b0;
        ev_done = 1'b0;
        ev_timeout = 1'b0;
        case (state_reg)
            PCS_IDLE: begin
                if (start_ok) begin
                    partial_next = sw_wdata_in[CMD_PARTIAL_BIT];
                    internal_next = sw_wdata_in[CMD_INTERNAL_BIT];
                    // whole direction register set to input: drivers off
                    addr_next = DEV_PIN_DIRECTION;
                    wdata_next = 8'hff;
                    wr_next = 1'b1;
                    state_next = PCS_DIR_OFF;
                end
            end
            PCS_DIR_OFF: begin
                addr_next = DEV_PULSE_CHANNEL_CONTROL;
                wdata_next = RESET_BYTE;
                wr_next = 1'b1;
                state_next = PCS_CTRL_CLR;
            end
            PCS_CTRL_CLR: begin
                addr_next = DEV_PERIOD_REGISTER;
                wdata_next = period_reg;
                wr_next = 1'b1;
                state_next = PCS_PERIOD;
            end
            PCS_PERIOD: begin
                wr_next = 1'b1;
                if (partial_reg) begin
                    // a partial first pulse is accepted: final write takes step four's place
                    addr_next = DEV_PULSE_CHANNEL_CONTROL;
                    wdata_next = final_cfg(config_reg, internal_reg);
                    state_next = PCS_DUTY_LO;
                end else begin
                    addr_next = DEV_DUTY_HIGH_REGISTER;
                    wdata_next = RESET_BYTE;
                    state_next = PCS_DUTY_HI;
                end
            end
            PCS_DUTY_HI: begin
                addr_next = DEV_DUTY_LOW_REGISTER;
                wdata_next = duty_lo_reg & DUTY_LOW_KEEP_MASK;
                wr_next = 1'b1;
                state_next = PCS_DUTY_LO;
            end
            PCS_DUTY_LO: begin
                addr_next = DEV_PERIPHERAL_FLAG_REGISTER_ONE;
                rd_next = 1'b1;
                state_next = PCS_FLAG_RD;
            end
            PCS_FLAG_RD: begin
                // read data stand only in the cycle after the strobe, so wait it out
                if (!rd_reg) begin
                    // read-modify-write keeps the other flags of that register
                    addr_next = DEV_PERIPHERAL_FLAG_REGISTER_ONE;
                    wdata_next = dev_rdata_in;
                    wdata_next[TIMER_OVERFLOW_FLAG_BIT] = 1'b0;
                    wr_next = 1'b1;
                    state_next = PCS_FLAG_WR;
                end
            end
            PCS_FLAG_WR: begin
                addr_next = DEV_PERIOD_TIMER_CONTROL;
                wdata_next = RESET_BYTE;
                wdata_next[PRESCALE_SELECT_LSB +: 3] = prescale_reg;
                wr_next = 1'b1;
                state_next = PCS_PRESCALE;
            end
            PCS_PRESCALE: begin
                addr_next = DEV_PERIOD_TIMER_CONTROL;
                wdata_next = wdata_reg;
                wdata_next[TIMER_ON_BIT] = 1'b1;
                wr_next = 1'b1;
                state_next = PCS_TMR_ON;
            end
            PCS_TMR_ON: begin
                addr_next = DEV_PULSE_CHANNEL_CONTROL;
                wdata_next = RESET_BYTE;
                wdata_next[CHANNEL_ENABLE_BIT] = 1'b1;
                wr_next = 1'b1;
                poll_cnt_next = '0;
                state_next = PCS_OUT_EN;
            end
            PCS_OUT_EN, PCS_POLL_RD: begin
                addr_next = DEV_PERIPHERAL_FLAG_REGISTER_ONE;
                rd_next = 1'b1;
                state_next = PCS_POLL_CHK;
            end
            PCS_POLL_CHK: begin
                if (rd_reg) begin
                    // strobe still out: the answer stands next cycle
                    state_next = PCS_POLL_CHK;
                end else if (dev_rdata_in[TIMER_OVERFLOW_FLAG_BIT]) begin
                    // pins stay input in internal-only use
                    addr_next = DEV_PIN_DIRECTION;
                    wdata_next = internal_reg ? 8'hff : ~pinmask_reg;
                    wr_next = 1'b1;
                    state_next = PCS_DIR_ON;
                end else if (poll_cnt_reg == POLL_MAX) begin
                    // give up rather than hang on a stopped timer
                    ev_timeout = 1'b1;
                    state_next = PCS_IDLE;
                end else begin
                    poll_cnt_next = poll_cnt_reg + 17'h00001;
                    state_next = PCS_POLL_RD;
                end
            end
            PCS_DIR_ON: begin
                addr_next = DEV_PULSE_CHANNEL_CONTROL;
                wdata_next = RESET_BYTE;
                wdata_next[CHANNEL_ENABLE_BIT] = 1'b1;
                wdata_next[PULSE_OUTPUT_ENABLE_BIT] = !internal_reg;
                wr_next = 1'b1;
                state_next = PCS_OE_SET;
            end
            PCS_OE_SET: begin
                wr_next = 1'b1;
                if (partial_reg) begin
                    addr_next = DEV_DUTY_HIGH_REGISTER;
                    wdata_next = duty_hi_reg;
                    state_next = PCS_LOAD_HI;
                end else begin
                    addr_next = DEV_PULSE_CHANNEL_CONTROL;
                    wdata_next = final_cfg(config_reg, internal_reg);
                    state_next = PCS_FINAL;
                end
            end
            PCS_FINAL: begin
                // running duty is loaded last, so the first period runs at zero duty
                addr_next = DEV_DUTY_HIGH_REGISTER;
                wdata_next = duty_hi_reg;
                wr_next = 1'b1;
                state_next = PCS_LOAD_HI;
            end
            PCS_LOAD_HI: begin
                addr_next = DEV_DUTY_LOW_REGISTER;
                wdata_next = duty_lo_reg;
                wr_next = 1'b1;
                state_next = PCS_LOAD_LO;
            end
            PCS_LOAD_LO: begin
                ev_done = 1'b1;
                state_next = PCS_IDLE;
            end
            default: begin
                state_next = PCS_IDLE;
            end
        endcase
    end

    always_comb begin
        period_next = period_reg;
        duty_hi_next = duty_hi_reg;
        duty_lo_next = duty_lo_reg;
        prescale_next = prescale_reg;
        config_next = config_reg;
        pinmask_next = pinmask_reg;
        int_mask_next = int_mask_reg;
        int_stat_next = int_stat_reg;
        rdata_next = RESET_BYTE;
        if (sw_hit(sw_addr_in, SW_PERIOD, sw_wr_in)) begin
            period_next = sw_wdata_in;
        end
        if (sw_hit(sw_addr_in, SW_DUTY_HI, sw_wr_in)) begin
            duty_hi_next = sw_wdata_in;
        end
        if (sw_hit(sw_addr_in, SW_DUTY_LO, sw_wr_in)) begin
            duty_lo_next = sw_wdata_in;
        end
        if (sw_hit(sw_addr_in, SW_PRESCALE, sw_wr_in)) begin
            prescale_next = sw_wdata_in[2:0];
        end
        if (sw_hit(sw_addr_in, SW_CONFIG, sw_wr_in)) begin
            config_next = sw_wdata_in;
        end
        if (sw_hit(sw_addr_in, SW_PINMASK, sw_wr_in)) begin
            pinmask_next = sw_wdata_in;
        end
        if (sw_hit(sw_addr_in, SW_INT_MASK, sw_wr_in)) begin
            int_mask_next = sw_wdata_in[1:0];
        end
        if (sw_hit(sw_addr_in, SW_INT_STAT, sw_wr_in)) begin
            int_stat_next = int_stat_reg & ~sw_wdata_in[1:0];
        end
        // set beats a clear in the same cycle
        int_stat_next = int_stat_next | {ev_timeout, ev_done};
        if (sw_rd_in) begin
            case (sw_addr_in)
                SW_CMD: rdata_next = {5'h00, internal_reg, partial_reg, 1'b0};
                SW_PERIOD: rdata_next = period_reg;
                SW_DUTY_HI: rdata_next = duty_hi_reg;
                SW_DUTY_LO: rdata_next = duty_lo_reg;
                SW_PRESCALE: rdata_next = {5'h00, prescale_reg};
                SW_CONFIG: rdata_next = config_reg;
                SW_PINMASK: rdata_next = pinmask_reg;
                SW_STATUS: rdata_next = {7'h00, state_reg != PCS_IDLE};
                SW_INT_STAT: rdata_next = {6'h00, int_stat_reg};
                SW_INT_MASK: rdata_next = {6'h00, int_mask_reg};
                default: rdata_next = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg <= PCS_IDLE;
            partial_reg <= 1'b0;
            internal_reg <= 1'b0;
            period_reg <= RESET_BYTE;
            duty_hi_reg <= RESET_BYTE;
            duty_lo_reg <= RESET_BYTE;
            prescale_reg <= 3'h0;
            config_reg <= RESET_BYTE;
            pinmask_reg <= RESET_BYTE;
            int_stat_reg <= RESET_INT;
            int_mask_reg <= RESET_INT;
            poll_cnt_reg <= '0;
            rdata_reg <= RESET_BYTE;
            addr_reg <= RESET_BYTE;
            wdata_reg <= RESET_BYTE;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            partial_reg <= partial_next;
            internal_reg <= internal_next;
            period_reg <= period_next;
            duty_hi_reg <= duty_hi_next;
            duty_lo_reg <= duty_lo_next;
            prescale_reg <= prescale_next;
            config_reg <= config_next;
            pinmask_reg <= pinmask_next;
            int_stat_reg <= int_stat_next;
            int_mask_reg <= int_mask_next;
            poll_cnt_reg <= poll_cnt_next;
            rdata_reg <= rdata_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    assign sw_rdata_out = rdata_reg;
    assign irq_out = |(int_stat_reg & int_mask_reg);
    assign dev_addr_out = addr_reg;
    assign dev_wdata_out = wdata_reg;
    assign dev_wr_out = wr_reg;
    assign dev_rd_out = rd_reg;

    dir_off_first_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        start_ok |=> dev_wr_out && dev_addr_out == DEV_PIN_DIRECTION && dev_wdata_out == 8'hff)
        else $error("start did not turn pin drivers off first");
    ctrl_clear_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_reg == PCS_DIR_OFF |-> ##1 dev_wr_out && dev_addr_out == DEV_PULSE_CHANNEL_CONTROL
        && dev_wdata_out == 8'h00 ##1 dev_addr_out == DEV_PERIOD_REGISTER)
        else $error("control clear not between direction and period writes");
    period_load_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        dev_wr_out && dev_addr_out == DEV_PERIOD_REGISTER |-> dev_wdata_out == period_reg)
        else $error("period written with wrong value");
    duty_zero_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_reg == PCS_DUTY_HI |-> dev_wdata_out == 8'h00 ##1 dev_wdata_out[7:6] == 2'h0)
        else $error("duty not cleared at step four");
    flag_clear_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_reg == PCS_FLAG_WR |-> !dev_wdata_out[TIMER_OVERFLOW_FLAG_BIT] ##2 dev_wdata_out[TIMER_ON_BIT])
        else $error("timer started without clearing overflow flag");
    timer_on_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_reg == PCS_PRESCALE |=> dev_wr_out && dev_wdata_out[PRESCALE_SELECT_LSB +: 3] == prescale_reg
        && $past(dev_wdata_out[PRESCALE_SELECT_LSB +: 3]) == prescale_reg)
        else $error("timer on write lost the prescale");
    overflow_seen_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_reg == PCS_POLL_CHK && !dev_rdata_in[TIMER_OVERFLOW_FLAG_BIT] |=> state_reg != PCS_DIR_ON)
        else $error("pins enabled before overflow");
    oe_after_dir_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_reg == PCS_DIR_ON && !internal_reg |=> dev_wdata_out[PULSE_OUTPUT_ENABLE_BIT]
        && dev_addr_out == DEV_PULSE_CHANNEL_CONTROL)
        else $error("output enable not set after drivers on");
    internal_pins_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        internal_reg && dev_wr_out && dev_addr_out == DEV_PIN_DIRECTION |-> dev_wdata_out == 8'hff)
        else $error("pin driven in internal-only use");
endmodule

// ---- pcs_dev_model.sv ----
// behavioural device: register file, period timer, overflow flag and pulse pin
module pcs_dev_model
    import pcs_pkg::*;
(
    input wire logic clk_in, // shared clock
    input wire logic rst_in, // synchronous reset, active high
    input wire logic [7:0] addr_in, // register address from controller
    input wire logic [7:0] wdata_in, // write data from controller
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    output logic [7:0] rdata_out, // read data, cycle after read only
    input wire logic stop_in, // freezes the period timer
    output logic pulse_out // channel output pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs_reg [0:6];
    logic [7:0] cnt_reg;
    logic [7:0] pre_reg;
    logic [15:0] log_q [$];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 7; i++) begin
                regs_reg[i] <= 8'h00;
            end
            // stale flag and dirty duty bits, so the controller must really clear them
            regs_reg[5] <= 8'h03;
            regs_reg[4] <= 8'hff;
            cnt_reg <= 8'h00;
            pre_reg <= 8'h00;
            rdata_out <= 8'h00;
        end else begin
            if (wr_in && addr_in < 8'h07) begin
                regs_reg[addr_in[2:0]] <= wdata_in;
                log_q.push_back({addr_in, wdata_in});
            end
            // outside the answer cycle the bus inverts its last value every cycle, so the stale value returns every second cycle
            rdata_out <= (rd_in && addr_in < 8'h07) ? regs_reg[addr_in[2:0]] : ~rdata_out;
            if (regs_reg[6][TIMER_ON_BIT] && !stop_in) begin
                if (pre_reg >= {5'h00, regs_reg[6][6:4]}) begin
                    pre_reg <= 8'h00;
                    if (cnt_reg >= regs_reg[2]) begin
                        cnt_reg <= 8'h00;
                        regs_reg[5][TIMER_OVERFLOW_FLAG_BIT] <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end else begin
                    pre_reg <= pre_reg + 8'h01;
                end
            end
        end
    end

    assign pulse_out = regs_reg[1][CHANNEL_ENABLE_BIT] && regs_reg[1][PULSE_OUTPUT_ENABLE_BIT]
        && (cnt_reg < regs_reg[3]);
endmodule

// ---- tb_pcs_startup_ctrl.sv ----
module tb_pcs_startup_ctrl
    import pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] sw_addr = 4'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic stop = 1'b0;
    logic [7:0] sw_rdata, dev_addr, dev_wdata, dev_rdata, v;
    logic irq, dev_wr, dev_rd, pulse;
    logic [15:0] exp_q [$];
    int err_total = 0;
    int checked = 0;

    always #20 clk = ~clk;

    pcs_startup_ctrl #(.POLL_LIMIT(4)) pcs_startup_ctrl_i (.ref_clk_in(clk), .rst_in(rst),
        .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
        .sw_rdata_out(sw_rdata), .irq_out(irq), .dev_addr_out(dev_addr), .dev_wdata_out(dev_wdata),
        .dev_wr_out(dev_wr), .dev_rd_out(dev_rd), .dev_rdata_in(dev_rdata));
    pcs_dev_model pcs_dev_model_i (.clk_in(clk), .rst_in(rst), .addr_in(dev_addr), .wdata_in(dev_wdata),
        .wr_in(dev_wr), .rd_in(dev_rd), .rdata_out(dev_rdata), .stop_in(stop), .pulse_out(pulse));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        if (err_total == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
        // let the edge's updates settle before anyone looks at outputs
        #1;
    endtask

    // high cycles of the pin over six cycles, whole periods at the settings used
    task automatic pulse_cnt(output logic [7:0] n);
        n = 8'h00;
        repeat (6) begin
            @(posedge clk);
            #1;
            n = n + {7'h00, pulse};
        end
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1;
        d = sw_rdata;
    endtask

    // a second start while busy must leave the device sequence untouched
    task automatic run(input logic [7:0] cmd);
        pcs_dev_model_i.log_q.delete();
        wr(SW_CMD, cmd);
        wr(SW_CMD, cmd);
        repeat (2) @(posedge clk);
        for (int i = 0; i < 400; i++) begin
            rd(SW_STATUS, v);
            if (v[0] === 1'b0) break;
            if (i == 399) begin
                err_total++;
                complete_run();
            end
        end
        chk(16'(pcs_dev_model_i.log_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) chk(pcs_dev_model_i.log_q[i], exp_q[i]);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 11; a++) begin
            rd(4'(a), v);
            chk({8'h00, v}, 16'h0000);
        end
        wr(4'ha, 8'h5a);
        rd(4'ha, v);
        chk({8'h00, v}, 16'h0000);
        wr(SW_PERIOD, 8'h02);
        wr(SW_DUTY_HI, 8'h01);
        wr(SW_DUTY_LO, 8'h80);
        wr(SW_CONFIG, 8'hc5);
        wr(SW_PINMASK, 8'h0c);
        wr(SW_INT_MASK, 8'h01);
        rd(SW_CONFIG, v);
        chk({8'h00, v}, 16'h00c5);
        // full ordered start-up with prompt overflow
        exp_q = {16'h00ff, 16'h0100, 16'h0202, 16'h0300, 16'h0400, 16'h0501, 16'h0600, 16'h0680,
            16'h0180, 16'h00f3, 16'h01c0, 16'h01c5, 16'h0301, 16'h0480};
        run(8'h01);
        pulse_cnt(v);
        chk({8'h00, v}, 16'h0002);
        chk({15'h0, irq}, 16'h0001);
        rd(SW_INT_STAT, v);
        chk({8'h00, v}, 16'h0001);
        wr(SW_INT_STAT, 8'h01);
        chk({15'h0, irq}, 16'h0000);
        // partial first pulse, slower overflow, event masked
        wr(SW_PRESCALE, 8'h01);
        wr(SW_DUTY_LO, 8'hc7);
        wr(SW_INT_MASK, 8'h00);
        exp_q = {16'h00ff, 16'h0100, 16'h0202, 16'h01c5, 16'h0501, 16'h0610, 16'h0690, 16'h0180,
            16'h00f3, 16'h01c0, 16'h0301, 16'h04c7};
        run(8'h03);
        chk({15'h0, irq}, 16'h0000);
        wr(SW_INT_MASK, 8'h01);
        chk({15'h0, irq}, 16'h0001);
        wr(SW_INT_STAT, 8'h01);
        chk({15'h0, irq}, 16'h0000);
        // internal-only: pins stay inputs, no output enable
        exp_q = {16'h00ff, 16'h0100, 16'h0202, 16'h0300, 16'h0407, 16'h0501, 16'h0610, 16'h0690,
            16'h0180, 16'h00ff, 16'h0180, 16'h0185, 16'h0301, 16'h04c7};
        run(8'h05);
        pulse_cnt(v);
        chk({8'h00, v}, 16'h0000);
        rd(SW_CMD, v);
        chk({8'h00, v}, 16'h0004);
        wr(SW_INT_STAT, 8'h01);
        // timer never overflows: polling gives up, nothing driven after the wait
        stop <= 1'b1;
        wr(SW_INT_MASK, 8'h02);
        exp_q = {16'h00ff, 16'h0100, 16'h0202, 16'h0300, 16'h0407, 16'h0501, 16'h0610, 16'h0690,
            16'h0180};
        run(8'h01);
        chk({15'h0, irq}, 16'h0001);
        rd(SW_INT_STAT, v);
        chk({8'h00, v}, 16'h0002);
        wr(SW_INT_STAT, 8'h02);
        chk({15'h0, irq}, 16'h0000);
        complete_run();
    end
endmodule
